// file: include/timer_wave_b_regs.vh
`ifndef TIMER_WAVE_B_REGS_VH
`define TIMER_WAVE_B_REGS_VH

// register byte offsets
`define OFS_LINE_B_MODE 8'h64
`define OFS_CHANNEL_STATUS 8'h70
`define OFS_IRQ_ENABLE 8'h74
`define OFS_IRQ_DISABLE 8'h78
`define OFS_IRQ_MASK 8'h7C

// decoded register selectors
`define SEL_NONE 3'h0
`define SEL_MODE 3'h1
`define SEL_STATUS 3'h2
`define SEL_ENABLE 3'h3
`define SEL_DISABLE 3'h4
`define SEL_MASK 3'h5

// line_b_mode fields
`define MODE_EDGE_LSB 8
`define MODE_SOURCE_LSB 10
`define MODE_TRIG_EN_BIT 12
`define MODE_MATCH_B_LSB 24
`define MODE_MATCH_C_LSB 26
`define MODE_EXT_EVT_LSB 28
`define MODE_SOFT_LSB 30
`define MODE_WRITE_MASK 32'hFF001F00
`define MODE_RESET 32'h00000000

// status / enable / disable / mask layout
`define BIT_OVERFLOW 0
`define BIT_MATCH_A 2
`define BIT_MATCH_B 3
`define BIT_MATCH_C 4
`define BIT_EXT_TRIG 7
`define BIT_CLOCK_STATE 8
`define BIT_LINE_A_LEVEL 9
`define BIT_LINE_B_LEVEL 10
`define BIT_LINE_B_CHANGE 16
`define BIT_LINE_A_CHANGE 17
`define BIT_CLOCK_PIN_CHANGE 18

// line B action codes
`define ACT_NONE 2'h0
`define ACT_SET 2'h1
`define ACT_CLEAR 2'h2
`define ACT_TOGGLE 2'h3

// event source and edge codes
`define SRC_LINE_B 2'h0
`define EDGE_NONE 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: core/pin_sync3.v
`timescale 1ns/10ps
module pin_sync3 #(
  parameter WIDTH = 1
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] level_o
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  integer i;

  // a bit only moves once stages two and three agree, filtering one-cycle metastable settling
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
      stage3 <= {WIDTH{1'b0}};
      level_o <= {WIDTH{1'b0}};
    end else if (ce_i) begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (stage2[i] == stage3[i]) begin
          level_o[i] <= stage3[i];
        end
      end
    end
  end

endmodule // pin_sync3

// file: core/line_b_driver.v
`timescale 1ns/10ps
`include "timer_wave_b_regs.vh"
module line_b_driver (
  input wire clk_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire is_input_i,
  input wire soft_evt_i,
  input wire ext_evt_i,
  input wire match_c_evt_i,
  input wire match_b_evt_i,
  input wire [1:0] soft_act_i,
  input wire [1:0] ext_act_i,
  input wire [1:0] match_c_act_i,
  input wire [1:0] match_b_act_i,
  output reg level_o,
  output reg oe_o
);

  reg [1:0] act;

  // events whose action is none do not compete for the pin
  always @* begin
    act = `ACT_NONE;
    if (soft_evt_i && soft_act_i != `ACT_NONE) begin
      act = soft_act_i;
    end else if (ext_evt_i && ext_act_i != `ACT_NONE) begin
      act = ext_act_i;
    end else if (match_c_evt_i && match_c_act_i != `ACT_NONE) begin
      act = match_c_act_i;
    end else if (match_b_evt_i && match_b_act_i != `ACT_NONE) begin
      act = match_b_act_i;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_o <= 1'b0;
      oe_o <= 1'b0;
    end else if (ce_i) begin
      oe_o <= !is_input_i;
      if (!is_input_i) begin
        case (act)
          `ACT_SET: level_o <= 1'b1;
          `ACT_CLEAR: level_o <= 1'b0;
          `ACT_TOGGLE: level_o <= !level_o;
          default: level_o <= level_o;
        endcase
      end
    end
  end

endmodule // line_b_driver

// file: core/timer_wave_b_status_irq.v
// What this block does
// - match B applies its action to line B
// - priority: software, external, match C, B
// - match C applies its action to line B
// - external event applies its action to line B
// - software trigger action; codes none/set/clear/toggle
// - line B actions ignored while line B input
// - status read clears all sticky flags
// - overflow wrap sets sticky overflow flag
// - match A sets sticky flag
// - match B sets sticky flag
// - match C sets sticky flag
// - enabled selected edge sets external trigger flag
// - mirror bits show line A, B levels
// - line B change bit reads 0 after change
// - line A change bit reads 0 after change
// - clock pin change bit reads 0 after change
// - enable writes set, disable writes clear enables
// - enable/disable use status bit layout
// - enabled set flag raises interrupt request
// - mask register reports enabled sources
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "timer_wave_b_regs.vh"
module timer_wave_b_status_irq #(
  parameter ADDR_W = 8
) (
  input wire clk_sys_i,
  input wire resetn_i,
  input wire ce_i,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire overflow_evt_i,
  input wire match_a_evt_i,
  input wire match_b_evt_i,
  input wire match_c_evt_i,
  input wire soft_trigger_i,
  input wire counter_clock_state_i,
  input wire wave_line_a_pin_i,
  input wire wave_line_b_pin_i,
  output wire wave_line_b_pin_o,
  output wire wave_line_b_pin_oe_o,
  input wire external_clock_pin_i,
  input wire ext_line0_i,
  input wire ext_line1_i,
  input wire ext_line2_i,
  output reg ext_trigger_o,
  output reg irq_o
);

  // flag vector order inside this block
  localparam F_OVF = 0;
  localparam F_MA = 1;
  localparam F_MB = 2;
  localparam F_MC = 3;
  localparam F_ETRG = 4;
  localparam F_CHG_B = 5;
  localparam F_CHG_A = 6;
  localparam F_CHG_CLK = 7;

  // synced pin vector order
  localparam [2:0] P_A = 3'h0;
  localparam [2:0] P_B = 3'h1;
  localparam [2:0] P_CLK = 3'h2;
  localparam [2:0] P_X0 = 3'h3;

  reg rst_q1;
  reg rst_n;

  // release is synchronous, assertion is immediate
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  function [2:0] reg_sel;
    input [ADDR_W-1:0] addr;
    begin
      case (addr)
        `OFS_LINE_B_MODE: reg_sel = `SEL_MODE;
        `OFS_CHANNEL_STATUS: reg_sel = `SEL_STATUS;
        `OFS_IRQ_ENABLE: reg_sel = `SEL_ENABLE;
        `OFS_IRQ_DISABLE: reg_sel = `SEL_DISABLE;
        `OFS_IRQ_MASK: reg_sel = `SEL_MASK;
        default: reg_sel = `SEL_NONE;
      endcase
    end
  endfunction

  // internal flag order to the software bit layout
  function [31:0] to_layout;
    input [7:0] f;
    begin
      to_layout = 32'h00000000;
      to_layout[`BIT_OVERFLOW] = f[F_OVF];
      to_layout[`BIT_MATCH_A] = f[F_MA];
      to_layout[`BIT_MATCH_B] = f[F_MB];
      to_layout[`BIT_MATCH_C] = f[F_MC];
      to_layout[`BIT_EXT_TRIG] = f[F_ETRG];
      to_layout[`BIT_LINE_B_CHANGE] = f[F_CHG_B];
      to_layout[`BIT_LINE_A_CHANGE] = f[F_CHG_A];
      to_layout[`BIT_CLOCK_PIN_CHANGE] = f[F_CHG_CLK];
    end
  endfunction

  function [7:0] from_layout;
    input [31:0] w;
    begin
      from_layout[F_OVF] = w[`BIT_OVERFLOW];
      from_layout[F_MA] = w[`BIT_MATCH_A];
      from_layout[F_MB] = w[`BIT_MATCH_B];
      from_layout[F_MC] = w[`BIT_MATCH_C];
      from_layout[F_ETRG] = w[`BIT_EXT_TRIG];
      from_layout[F_CHG_B] = w[`BIT_LINE_B_CHANGE];
      from_layout[F_CHG_A] = w[`BIT_LINE_A_CHANGE];
      from_layout[F_CHG_CLK] = w[`BIT_CLOCK_PIN_CHANGE];
    end
  endfunction

  function [31:0] lane_mask;
    input [3:0] strb;
    begin
      lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    end
  endfunction

  // pin synchronisation
  wire [5:0] pins_sync;
  reg [5:0] pins_prev;

  pin_sync3 #(
    .WIDTH(6)
  ) u_pin_sync (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .async_i({ext_line2_i, ext_line1_i, ext_line0_i, external_clock_pin_i, wave_line_b_pin_i, wave_line_a_pin_i}),
    .level_o(pins_sync)
  );

  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pins_prev <= 6'h00;
    end else if (ce_i) begin
      pins_prev <= pins_sync;
    end
  end

  wire [5:0] pin_rise = pins_sync & ~pins_prev;
  wire [5:0] pin_fall = ~pins_sync & pins_prev;

  // mode register
  reg [31:0] line_b_mode;
  wire [1:0] ext_event_edge_select = line_b_mode[`MODE_EDGE_LSB +: 2];
  wire [1:0] ext_event_source = line_b_mode[`MODE_SOURCE_LSB +: 2];
  wire ext_trigger_enable = line_b_mode[`MODE_TRIG_EN_BIT];
  wire line_b_is_input = (ext_event_source == `SRC_LINE_B);

  // edges are kept per line so a source switch never fakes an edge
  wire [1:0] src_idx = ext_event_source;
  wire [2:0] src_pin = (src_idx == `SRC_LINE_B) ? P_B : (P_X0 + {1'b0, src_idx} - 3'h1);
  reg ext_evt;

  always @* begin
    case (ext_event_edge_select)
      `EDGE_RISE: ext_evt = pin_rise[src_pin];
      `EDGE_FALL: ext_evt = pin_fall[src_pin];
      `EDGE_BOTH: ext_evt = pin_rise[src_pin] | pin_fall[src_pin];
      default: ext_evt = 1'b0;
    endcase
  end

  wire ext_trig_evt = ext_evt & ext_trigger_enable;

  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ext_trigger_o <= 1'b0;
    end else if (ce_i) begin
      ext_trigger_o <= ext_trig_evt;
    end
  end

  // line B waveform output
  line_b_driver u_line_b (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .is_input_i(line_b_is_input),
    .soft_evt_i(soft_trigger_i),
    .ext_evt_i(ext_evt),
    .match_c_evt_i(match_c_evt_i),
    .match_b_evt_i(match_b_evt_i),
    .soft_act_i(line_b_mode[`MODE_SOFT_LSB +: 2]),
    .ext_act_i(line_b_mode[`MODE_EXT_EVT_LSB +: 2]),
    .match_c_act_i(line_b_mode[`MODE_MATCH_C_LSB +: 2]),
    .match_b_act_i(line_b_mode[`MODE_MATCH_B_LSB +: 2]),
    .level_o(wave_line_b_pin_o),
    .oe_o(wave_line_b_pin_oe_o)
  );

  // AXI4-Lite write side
  reg aw_held;
  reg w_held;
  reg [ADDR_W-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  assign s_axi_awready = ce_i & ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ce_i & ~w_held & ~s_axi_bvalid;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire [ADDR_W-1:0] wr_addr = aw_take ? s_axi_awaddr : aw_addr;
  wire [31:0] wr_data = w_take ? s_axi_wdata : w_data;
  wire [3:0] wr_strb = w_take ? s_axi_wstrb : w_strb;
  wire wr_go = ce_i & (aw_held | aw_take) & (w_held | w_take) & ~s_axi_bvalid;
  wire [2:0] wr_sel = reg_sel(wr_addr);
  wire [31:0] wr_bits = wr_data & lane_mask(wr_strb);

  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= {ADDR_W{1'b0}};
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (ce_i) begin
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_sel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end else begin
        aw_held <= aw_held | aw_take;
        w_held <= w_held | w_take;
        if (s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // writes to status or mask are accepted and ignored
  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      line_b_mode <= `MODE_RESET;
    end else if (ce_i && wr_go && wr_sel == `SEL_MODE) begin
      line_b_mode <= (line_b_mode & ~(lane_mask(wr_strb) & `MODE_WRITE_MASK)) | (wr_bits & `MODE_WRITE_MASK);
    end
  end

  // interrupt enables
  reg [7:0] irq_mask;
  wire [7:0] en_bits = (wr_go && wr_sel == `SEL_ENABLE) ? from_layout(wr_bits) : 8'h00;
  wire [7:0] dis_bits = (wr_go && wr_sel == `SEL_DISABLE) ? from_layout(wr_bits) : 8'h00;

  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= 8'h00;
    end else if (ce_i) begin
      irq_mask <= (irq_mask | en_bits) & ~dis_bits;
    end
  end

  // AXI4-Lite read side
  assign s_axi_arready = ce_i & ~s_axi_rvalid;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire [2:0] rd_sel = reg_sel(s_axi_araddr);
  wire status_read = ar_take & (rd_sel == `SEL_STATUS);

  // sticky flags
  reg [7:0] flags;
  wire [7:0] flag_set;

  assign flag_set[F_OVF] = overflow_evt_i;
  assign flag_set[F_MA] = match_a_evt_i;
  assign flag_set[F_MB] = match_b_evt_i;
  assign flag_set[F_MC] = match_c_evt_i;
  assign flag_set[F_ETRG] = ext_trig_evt;
  assign flag_set[F_CHG_B] = pins_sync[P_B] ^ pins_prev[P_B];
  assign flag_set[F_CHG_A] = pins_sync[P_A] ^ pins_prev[P_A];
  assign flag_set[F_CHG_CLK] = pins_sync[P_CLK] ^ pins_prev[P_CLK];

  // set wins over the read clear so a coincident event is kept
  wire [7:0] next_flags = (flags & ~{8{status_read}}) | flag_set;

  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      flags <= 8'h00;
    end else if (ce_i) begin
      flags <= next_flags;
    end
  end

  // change flags read inverted: 0 means a change was seen
  wire [7:0] status_view = flags ^ ((8'h01 << F_CHG_B) | (8'h01 << F_CHG_A) | (8'h01 << F_CHG_CLK));
  reg [31:0] status_word;

  always @* begin
    status_word = to_layout(status_view);
    status_word[`BIT_CLOCK_STATE] = counter_clock_state_i;
    status_word[`BIT_LINE_A_LEVEL] = pins_sync[P_A];
    status_word[`BIT_LINE_B_LEVEL] = pins_sync[P_B];
  end

  reg [31:0] rd_word;

  always @* begin
    case (rd_sel)
      `SEL_MODE: rd_word = line_b_mode;
      `SEL_STATUS: rd_word = status_word;
      `SEL_MASK: rd_word = to_layout(irq_mask);
      default: rd_word = 32'h00000000;
    endcase
  end

  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (ce_i) begin
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= (rd_sel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // interrupt request, one cycle behind the flags
  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(flags & irq_mask);
    end
  end

endmodule // timer_wave_b_status_irq

// file: tb/timer_wave_b_status_irq_props.sv
`timescale 1ns/10ps
module timer_wave_b_status_irq_props (
  input wire clk_sys_i,
  input wire resetn_i,
  input wire ce_i,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire irq_o
);
  default clocking dc @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);

  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing one cycle after address");
  AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
  AST_ONE_READ: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted while answer pending");
  AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response missing");
  AST_AW_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address accepted while response pending");
  AST_W_BUSY: assert property (s_axi_bvalid |-> !s_axi_wready)
    else $error("write data accepted while response pending");
  AST_FREEZE: assert property (!ce_i |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
    else $error("bus accepted while clock enable low");
  // irq can only drop through a status read or a disable write
  AST_IRQ_FALL: assert property ($fell(irq_o) |-> $past(s_axi_rvalid) || $past(s_axi_bvalid))
    else $error("interrupt dropped without read or disable");
endmodule // timer_wave_b_status_irq_props

// file: tb/pin_world.sv
`timescale 1ns/10ps
module pin_world (
  input wire [5:0] lvl_i,
  input wire b_out_i,
  input wire b_oe_i,
  output wire line_a_o,
  output wire line_b_o,
  output wire clk_pin_o,
  output wire [2:0] ext_o
);
  // pins move off the clock edge, as truly asynchronous inputs would
  assign #2 line_b_o = b_oe_i ? b_out_i : lvl_i[0];
  assign #2 line_a_o = lvl_i[5];
  assign #2 clk_pin_o = lvl_i[4];
  assign #2 ext_o = lvl_i[3:1];
endmodule // pin_world

// file: tb/timer_wave_b_status_irq_bench.sv
`timescale 1ns/10ps
`include "timer_wave_b_regs.vh"
module timer_wave_b_status_irq_bench;
  localparam logic [31:0] SRC0 = 32'h1 << `MODE_SOURCE_LSB;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic ce = 1'b1;
  logic ccs = 1'b0;
  logic [4:0] ev = 5'h00;
  logic [5:0] pin = 6'h00;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, lb_o, lb_oe, xtrg, irq, pa, pb, pc;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] px;
  int errors = 0;
  int num_checks = 0;

  initial begin
    forever #2.5 clk_sys_i = !clk_sys_i;
  end

  timer_wave_b_status_irq i_timer_wave_b_status_irq (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ce_i(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .overflow_evt_i(ev[4]), .match_a_evt_i(ev[3]), .match_b_evt_i(ev[2]),
    .match_c_evt_i(ev[1]), .soft_trigger_i(ev[0]), .counter_clock_state_i(ccs), .wave_line_a_pin_i(pa),
    .wave_line_b_pin_i(pb), .wave_line_b_pin_o(lb_o), .wave_line_b_pin_oe_o(lb_oe),
    .external_clock_pin_i(pc), .ext_line0_i(px[0]), .ext_line1_i(px[1]), .ext_line2_i(px[2]),
    .ext_trigger_o(xtrg), .irq_o(irq));

  pin_world i_pin_world (.lvl_i(pin), .b_out_i(lb_o), .b_oe_i(lb_oe), .line_a_o(pa), .line_b_o(pb),
    .clk_pin_o(pc), .ext_o(px));

  task conclude;
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
    begin
      num_checks++;
      if ((g & m) !== (e & m)) begin
        errors++;
        $display("[ERR] %0t got %h exp %h", $time, g & m, e & m);
      end
    end
  endtask

  task chkb(input logic g, input logic e);
    chk(32'(g), 32'(e), 32'h1);
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task evt(input logic [4:0] e);
    begin
      @(posedge clk_sys_i);
      ev <= e;
      @(posedge clk_sys_i);
      ev <= 5'h00;
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    begin
      @(posedge clk_sys_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
        @(posedge clk_sys_i);
        if (awready === 1'b1) awvalid <= 1'b0;
        if (wready === 1'b1) wvalid <= 1'b0;
        n++;
      end while (bvalid !== 1'b1 && n < 50);
      bready <= 1'b0;
      if (n >= 50) begin
        errors++;
        conclude();
      end
      chk(32'(bresp), 32'(er), 32'h3);
    end
  endtask

  // e pulses events on the address edge, so they coincide with the read
  task rd(input logic [7:0] a, input logic [4:0] e, input int lag, input logic [31:0] x, input logic [31:0] m,
          input logic [1:0] er);
    int n;
    begin
      @(posedge clk_sys_i);
      araddr <= a;
      arvalid <= 1'b1;
      ev <= e;
      rready <= (lag == 0);
      n = 0;
      do begin
        @(posedge clk_sys_i);
        ev <= 5'h00;
        if (arready === 1'b1) arvalid <= 1'b0;
        if (rvalid === 1'b1 && rready !== 1'b1 && n >= lag) rready <= 1'b1;
        n++;
      end while (!(rvalid === 1'b1 && rready === 1'b1) && n < 50);
      rready <= 1'b0;
      if (n >= 50) begin
        errors++;
        conclude();
      end
      chk(rdata, x, m);
      chk(32'(rresp), 32'(er), 32'h3);
    end
  endtask

  task t_reset;
    begin
      rd(`OFS_CHANNEL_STATUS, 5'h0, 0, 32'h0007_0000, 32'h0007_079D, `RESP_OKAY);
      rd(`OFS_IRQ_MASK, 5'h0, 0, 32'h0, 32'hFFFFFFFF, `RESP_OKAY);
      rd(`OFS_IRQ_ENABLE, 5'h0, 0, 32'h0, 32'hFFFFFFFF, `RESP_OKAY);
      rd(`OFS_LINE_B_MODE, 5'h0, 0, 32'h0, 32'hFFFFFFFF, `RESP_OKAY);
      rd(8'h40, 5'h0, 0, 32'h0, 32'hFFFFFFFF, `RESP_SLVERR);
      wr(8'h40, 32'hFFFFFFFF, `RESP_SLVERR);
      wr(`OFS_IRQ_MASK, 32'hFFFFFFFF, `RESP_OKAY);
      rd(`OFS_IRQ_MASK, 5'h0, 0, 32'h0, 32'hFFFFFFFF, `RESP_OKAY);
    end
  endtask

  task t_flags;
    begin
      evt(5'b11110);
      rd(`OFS_CHANNEL_STATUS, 5'h0, 2, 32'h1D, 32'h1D, `RESP_OKAY);
      rd(`OFS_CHANNEL_STATUS, 5'b01000, 0, 32'h0, 32'h1D, `RESP_OKAY);
      rd(`OFS_CHANNEL_STATUS, 5'h0, 0, 32'h04, 32'h1D, `RESP_OKAY);
    end
  endtask

  task t_irq;
    begin
      wr(`OFS_IRQ_ENABLE, 32'h0007_009D, `RESP_OKAY);
      rd(`OFS_IRQ_MASK, 5'h0, 0, 32'h0007_009D, 32'hFFFFFFFF, `RESP_OKAY);
      wr(`OFS_IRQ_DISABLE, 32'h0, `RESP_OKAY);
      rd(`OFS_IRQ_MASK, 5'h0, 0, 32'h0007_009D, 32'hFFFFFFFF, `RESP_OKAY);
      wr(`OFS_IRQ_DISABLE, 32'h0007_0098, `RESP_OKAY);
      rd(`OFS_IRQ_MASK, 5'h0, 0, 32'h05, 32'hFFFFFFFF, `RESP_OKAY);
      chkb(irq, 1'b0);
      evt(5'b10000);
      cyc(2);
      chkb(irq, 1'b1);
      wr(`OFS_IRQ_DISABLE, 32'h1, `RESP_OKAY);
      cyc(1);
      chkb(irq, 1'b0);
      evt(5'b01000);
      cyc(2);
      chkb(irq, 1'b1);
      rd(`OFS_CHANNEL_STATUS, 5'h0, 0, 32'h05, 32'h1D, `RESP_OKAY);
      cyc(1);
      chkb(irq, 1'b0);
    end
  endtask

  task t_lineb;
    logic [1:0] c;
    logic lv;
    int n;
    begin
      lv = 1'b0;
      for (int i = 0; i < 4; i++) begin
        c = 2'(i + 1);
        wr(`OFS_LINE_B_MODE, (32'(c) << `MODE_MATCH_B_LSB) | SRC0, `RESP_OKAY);
        evt(5'b00100);
        cyc(1);
        lv = (c == `ACT_SET) ? 1'b1 : (c == `ACT_CLEAR) ? 1'b0 : (c == `ACT_TOGGLE) ? !lv : lv;
        chkb(lb_oe, 1'b1);
        chkb(lb_o, lv);
      end
      rd(`OFS_CHANNEL_STATUS, 5'h0, 0, 32'(lv) << `BIT_LINE_B_LEVEL, 32'h0001_0400, `RESP_OKAY);
      wr(`OFS_LINE_B_MODE, (32'h2 << `MODE_SOFT_LSB) | (32'h1 << `MODE_EXT_EVT_LSB) | (32'h3 << `MODE_MATCH_C_LSB)
        | (32'h1 << `MODE_MATCH_B_LSB) | SRC0, `RESP_OKAY);
      for (int i = 0; i < 3; i++) begin
        evt(i == 2 ? 5'b00111 : 5'b00110);
        cyc(1);
        lv = (i == 2) ? 1'b0 : !lv;
        chkb(lb_o, lv);
      end
      rd(`OFS_CHANNEL_STATUS, 5'h0, 0, 32'h0000_0018, 32'h0001_0018, `RESP_OKAY);
      wr(`OFS_LINE_B_MODE, (32'h3 << `MODE_EXT_EVT_LSB) | (32'h1 << `MODE_TRIG_EN_BIT) | SRC0
        | (32'(`EDGE_RISE) << `MODE_EDGE_LSB), `RESP_OKAY);
      pin[1] <= 1'b1;
      for (n = 0; n < 20 && xtrg !== 1'b1; n++) cyc(1);
      chkb(xtrg, 1'b1);
      cyc(2);
      chkb(lb_o, !lv);
      rd(`OFS_CHANNEL_STATUS, 5'h0, 0, 32'h80, 32'h80, `RESP_OKAY);
      pin[1] <= 1'b0;
      cyc(8);
      rd(`OFS_CHANNEL_STATUS, 5'h0, 0, 32'h0, 32'h80, `RESP_OKAY);
      // second external line, both edges count
      wr(`OFS_LINE_B_MODE, (32'h2 << `MODE_SOURCE_LSB) | (32'h1 << `MODE_TRIG_EN_BIT)
        | (32'(`EDGE_BOTH) << `MODE_EDGE_LSB), `RESP_OKAY);
      pin[2] <= 1'b1;
      cyc(8);
      rd(`OFS_CHANNEL_STATUS, 5'h0, 0, 32'h80, 32'h80, `RESP_OKAY);
      pin[2] <= 1'b0;
      cyc(8);
      rd(`OFS_CHANNEL_STATUS, 5'h0, 0, 32'h80, 32'h80, `RESP_OKAY);
      // clear action must be ignored once line B is an input
      wr(`OFS_LINE_B_MODE, 32'h2 << `MODE_MATCH_B_LSB, `RESP_OKAY);
      evt(5'b00100);
      cyc(1);
      chkb(lb_oe, 1'b0);
      chkb(lb_o, !lv);
    end
  endtask

  task t_pins;
    begin
      // frozen cycles only delay the synchronisers, nothing is lost
      ce <= 1'b0;
      cyc(3);
      ce <= 1'b1;
      pin[5] <= 1'b1;
      pin[4] <= 1'b1;
      ccs <= 1'b1;
      cyc(10);
      rd(`OFS_CHANNEL_STATUS, 5'h0, 0, 32'h0000_0300, 32'h0006_0300, `RESP_OKAY);
      rd(`OFS_CHANNEL_STATUS, 5'h0, 0, 32'h0006_0300, 32'h0006_0300, `RESP_OKAY);
    end
  endtask

  initial begin
    repeat (2) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    t_reset();
    t_flags();
    t_irq();
    t_lineb();
    t_pins();
    conclude();
  end
endmodule // timer_wave_b_status_irq_bench

bind timer_wave_b_status_irq timer_wave_b_status_irq_props i_timer_wave_b_status_irq_props (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ce_i(ce_i), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .irq_o(irq_o));
